/* File: l2_sram_ecc_controller_tb_top.sv */
// Self-checking bench: register access, ECC write paths, bank conflict
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module l2_sram_ecc_controller_tb_top
   import l2sc_pkg::*;
;
   logic              clk, rst, hung, axi_hung, ok, ok2;
   logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, d, dma_wr_data, dma_rd_rdata;
   logic [3:0]        s_axi_wstrb, dma_wr_strb;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]        s_axi_bresp, s_axi_rresp, r;
   logic              core_wr_valid, core_wr_ready, core_wr_done, core_rd_valid, core_rd_ready, core_rd_rvalid;
   logic              dma_wr_valid, dma_wr_ready, dma_wr_done, dma_rd_valid, dma_rd_ready, dma_rd_rvalid;
   logic [ADDR_W-1:0] core_wr_addr, core_rd_addr, dma_wr_addr, dma_rd_addr;
   logic [63:0]       core_wr_data, core_rd_rdata, q, q2;
   logic [7:0]        core_wr_strb;
   int                num_errors, samples_checked, lat, cyc, cyc2, i;

   // Short banks keep the run small
   l2sc_ctrl #(.ROWS(16)) u_dut (
      .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .core_wr_valid, .core_wr_ready, .core_wr_addr, .core_wr_data, .core_wr_strb, .core_wr_done,
      .core_rd_valid, .core_rd_ready, .core_rd_addr, .core_rd_rvalid, .core_rd_rdata,
      .dma_wr_valid, .dma_wr_ready, .dma_wr_addr, .dma_wr_data, .dma_wr_strb, .dma_wr_done,
      .dma_rd_valid, .dma_rd_ready, .dma_rd_addr, .dma_rd_rvalid, .dma_rd_rdata);

   l2sc_xbar_model u_xbar (
      .clk, .core_wr_valid, .core_wr_ready, .core_wr_addr, .core_wr_data, .core_wr_strb, .core_wr_done,
      .core_rd_valid, .core_rd_ready, .core_rd_addr, .core_rd_rvalid, .core_rd_rdata,
      .dma_wr_valid, .dma_wr_ready, .dma_wr_addr, .dma_wr_data, .dma_wr_strb, .dma_wr_done,
      .dma_rd_valid, .dma_rd_ready, .dma_rd_addr, .dma_rd_rvalid, .dma_rd_rdata, .hung);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic finish_test;
      if (num_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      if (hung === 1'b1 || axi_hung) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] br);
      int k;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      br = s_axi_bresp;
      if (k == 50) axi_hung = 1'b1;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
      int k;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      if (k == 50) axi_hung = 1'b1;
   endtask : axi_rd

   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, axi_hung} = '0;
      s_axi_wstrb = 4'hf;
      num_errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         axi_rd(8'(i * 4), d, r);
         `CHK("register reset value", 32'h0, d)
      end
      axi_rd(8'h10, d, r);
      `CHK("unmapped read resp", RESP_SLVERR, r)
      `CHK("unmapped read data", 32'h0, d)
      axi_wr(8'h20, 32'h1, r);
      `CHK("unmapped write resp", RESP_SLVERR, r)
      axi_wr(REG_ECC, 32'h01, r);
      `CHK("ecc enable resp", RESP_OKAY, r)
      axi_wr(REG_RPC, 32'h10, r);
      axi_wr(REG_WPC, 32'h10, r);
      axi_wr(REG_STAT, 32'hff, r);
      axi_rd(REG_RPC, d, r);
      `CHK("read priority counts", 32'h10, d)
      axi_rd(REG_WPC, d, r);
      `CHK("write priority counts", 32'h10, d)
      u_xbar.wr(0, 18'h0, 64'h1122334455667788, 8'hff, lat);
      `CHK("direct write latency", 1, lat)
      u_xbar.wr(0, 18'h0, 64'haa, 8'h01, lat);
      `CHK("narrow ecc write latency", 3, lat)
      u_xbar.rd(0, 18'h0, 1, 0, cyc, ok, q);
      `CHK("merged word", 64'h11223344556677aa, q)
      `CHK("ecc read latency", 1'b1, ok)
      u_xbar.wr(0, 18'h8, 64'hcafef00d12345678, 8'hff, lat);
      u_xbar.wr(0, 18'h8, 64'hbb00, 8'h02, lat);
      `CHK("narrow plain write latency", 1, lat)
      u_xbar.rd(0, 18'h8, 1, 0, cyc, ok, q);
      `CHK("plain merged word", 64'hcafef00d1234bb78, q)
      u_xbar.wr(1, 18'h4, 64'hdeadbeef, 8'h0f, lat);
      `CHK("dma word write latency", 1, lat)
      u_xbar.rd(0, 18'h0, 1, 0, cyc, ok, q);
      `CHK("dma upper half in word", 64'hdeadbeef556677aa, q)
      u_xbar.wr(1, 18'h0, 64'h9999, 8'h03, lat);
      `CHK("dma narrow ecc latency", 3, lat)
      u_xbar.rd(1, 18'h0, 1, 0, cyc, ok, q);
      `CHK("dma read half", 64'h55669999, q)
      `CHK("dma read valid", 1'b1, ok)
      // Rows jump around: no row-change penalty expected
      u_xbar.rd(0, 18'h8, 8, 64, cyc, ok, q);
      `CHK("nonsequential burst cycles", 8, cyc)
      // Write last, so the read goes first
      u_xbar.wr(0, 18'h18, 64'h2, 8'hff, lat);
      fork
         u_xbar.wr(0, 18'h10, 64'h1, 8'hff, lat);
         u_xbar.rd(0, 18'h8, 2, 0, cyc2, ok2, q2);
      join
      `CHK("concurrent write latency", 1, lat)
      `CHK("concurrent read cycles", 3, cyc2)
      `CHK("concurrent read done", 1'b1, ok2)
      fork
         u_xbar.rd(0, 18'h10, 12, 64, cyc, ok, q);
         u_xbar.rd(1, 18'h10, 2, 64, cyc2, ok2, q2);
      join
      `CHK("dma conflict cycles", 6, cyc2)
      axi_wr(REG_RPC, 32'h00, r);
      fork
         u_xbar.rd(0, 18'h10, 8, 64, cyc, ok, q);
         u_xbar.rd(1, 18'h10, 1, 64, cyc2, ok2, q2);
      join
      `CHK("dma starved with zero count", 9, cyc2)
      axi_rd(REG_STAT, d, r);
      `CHK("status read only and clean", 32'h0, d)
      finish_test();
   end
endmodule : l2_sram_ecc_controller_tb_top
`default_nettype wire

/* File: l2sc_ctrl.sv */
// Level-2 SRAM controller: core and DMA ports, eight ECC banks, AXI4-Lite control
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Controller and array run on the system clock, at most half the core clock.
// R2 - Port 0 is a 64-bit port for core traffic.
// R3 - Port 1 is a 32-bit port for DMA traffic.
// R4 - Each port has its own read channel and write channel.
// R5 - Every array access is one 64-bit word, whatever the request width.
// R6 - Eight independent banks, up to 256 KB, each may have ECC.
// R7 - A sub-32-bit write to an ECC bank is a two-cycle read then a one-cycle write.
// R8 - Narrow or unaligned narrow accesses to an ECC bank cost two extra cycles.
// R9 - ECC adds no cycles to reads.
// R10 - Sequential and random addresses run at the same rate.
// R11 - Under a bank conflict DMA gets at best one access every three cycles.
// R12 - Read and write priority counts per port; core 0 and DMA 1 favour DMA most.
// R13 - DMA masters should use bursts of at least 8 bytes.
// R14 - Several DMA channels should use 16- or 32-byte bursts.
// R15 - Masters should use both ports and both channels in parallel.
// R16 - ECC enable is held per bank; only enabled banks use read-modify-write.
// R17 - Aligned writes of 32 bits or more are written directly with new check bits.
module l2sc_ctrl
   import l2sc_pkg::*;
#(
   parameter int ROWS = BANK_ROWS
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [REG_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output var logic [1:0]         s_axi_bresp,
   output var logic               s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [REG_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output var logic [31:0]        s_axi_rdata,
   output var logic [1:0]         s_axi_rresp,
   output var logic               s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              core_wr_valid,
   output logic                   core_wr_ready,
   input  wire logic [ADDR_W-1:0] core_wr_addr,
   input  wire logic [63:0]       core_wr_data,
   input  wire logic [7:0]        core_wr_strb,
   output var logic               core_wr_done,
   input  wire logic              core_rd_valid,
   output logic                   core_rd_ready,
   input  wire logic [ADDR_W-1:0] core_rd_addr,
   output var logic               core_rd_rvalid,
   output var logic [63:0]        core_rd_rdata,
   input  wire logic              dma_wr_valid,
   output logic                   dma_wr_ready,
   input  wire logic [ADDR_W-1:0] dma_wr_addr,
   input  wire logic [31:0]       dma_wr_data,
   input  wire logic [3:0]        dma_wr_strb,
   output var logic               dma_wr_done,
   input  wire logic              dma_rd_valid,
   output logic                   dma_rd_ready,
   input  wire logic [ADDR_W-1:0] dma_rd_addr,
   output var logic               dma_rd_rvalid,
   output var logic [31:0]        dma_rd_rdata
);
   localparam int RW = $clog2(ROWS);

   // Hamming code over 32 data bits, positions 1..38 with powers of two as checks
   function automatic logic [CHK_W-1:0] ecc_enc(input logic [31:0] d);
      logic [CHK_W-1:0] c;
      int               k;
      c = '0;
      k = 0;
      for (int p = 1; p <= HAM_LEN; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (d[k]) c = c ^ CHK_W'(p);
            k++;
         end
      end
      return c;
   endfunction : ecc_enc

   function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [CHK_W-1:0] syn);
      logic [31:0] r;
      int          k;
      r = d;
      k = 0;
      for (int p = 1; p <= HAM_LEN; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (syn == CHK_W'(p)) r[k] = ~r[k];
            k++;
         end
      end
      return r;
   endfunction : ecc_fix

   function automatic logic [63:0] byte_merge(input logic [63:0] nd, input logic [7:0] s, input logic [63:0] od);
      logic [63:0] r;
      r = od;
      for (int b = 0; b < 8; b++) begin
         if (s[b]) r[8*b +: 8] = nd[8*b +: 8];
      end
      return r;
   endfunction : byte_merge

   function automatic logic partial(input logic [3:0] s);
      return (s != 4'h0) && (s != 4'hf);
   endfunction : partial

   logic [63:0]          mem_q [NUM_BANKS][ROWS];
   logic [2*CHK_W-1:0]   chk_q [NUM_BANKS][ROWS];
   logic [7:0]           rpc_q;
   logic [7:0]           wpc_q;
   logic [7:0]           ecc_en_q;
   logic [ERR_W-1:0]     err_cnt_q;
   logic [ERR_W-1:0]     err_cnt_d;
   logic [WAIT_W-1:0]    wait_q;
   logic [WAIT_W-1:0]    wait_d;

   // Index 0 is the core port, 1 the DMA port
   logic                 wv     [2];
   logic                 rv     [2];
   logic [ADDR_W-1:0]    wa     [2];
   logic [ADDR_W-1:0]    ra     [2];
   logic [63:0]          wd     [2];
   logic [7:0]           ws     [2];
   logic                 sel_wr [2];
   logic                 want   [2];
   logic                 busy   [2];
   logic                 narrow [2];
   logic                 grant  [2];
   logic                 wen    [2];
   logic                 rd_err [2];
   logic [BANK_W-1:0]    bank   [2];
   logic [RW-1:0]        row    [2];
   logic [63:0]          view   [2];
   logic [63:0]          wword  [2];
   logic [2*CHK_W-1:0]   wchk   [2];
   l2sc_st_type          st     [2];

   assign wv[0] = core_wr_valid;
   assign rv[0] = core_rd_valid;
   assign wa[0] = core_wr_addr;
   assign ra[0] = core_rd_addr;
   assign wd[0] = core_wr_data;
   assign ws[0] = core_wr_strb;
   assign wv[1] = dma_wr_valid;
   assign rv[1] = dma_rd_valid;
   assign wa[1] = dma_wr_addr;
   assign ra[1] = dma_rd_addr;
   // DMA words are widened to a full array word; strobes pick the half
   assign wd[1] = {2{dma_wr_data}}; // R3 R5
   assign ws[1] = dma_wr_addr[2] ? {dma_wr_strb, 4'h0} : {4'h0, dma_wr_strb}; // R5

   for (genvar p = 0; p < 2; p++) begin : g_port
      l2sc_st_type        st_q;
      logic               pref_wr_q;
      logic [BANK_W-1:0]  rb_q;
      logic [RW-1:0]      rr_q;
      logic [63:0]        rmw_data_q;
      logic [7:0]         rmw_strb_q;
      logic [63:0]        merged_q;
      logic [ADDR_W-1:0]  req_a;
      logic [63:0]        raw;
      logic [2*CHK_W-1:0] rawc;
      logic [CHK_W-1:0]   syn_lo;
      logic [CHK_W-1:0]   syn_hi;
      logic [63:0]        merged;
      logic               idle;

      assign idle      = (st_q == ST_IDLE);
      // Read and write channels alternate when both are pending
      assign sel_wr[p] = wv[p] && (!rv[p] || pref_wr_q); // R4
      assign req_a     = sel_wr[p] ? wa[p] : ra[p];
      assign st[p]     = st_q;
      assign want[p]   = idle && (wv[p] || rv[p]);
      assign bank[p]   = idle ? req_a[BANK_LSB +: BANK_W] : rb_q; // R6
      assign row[p]    = idle ? req_a[ROW_LSB +: RW] : rr_q;
      assign raw       = mem_q[bank[p]][row[p]];
      assign rawc      = chk_q[bank[p]][row[p]];
      assign syn_lo    = rawc[CHK_W-1:0] ^ ecc_enc(raw[31:0]);
      assign syn_hi    = rawc[2*CHK_W-1:CHK_W] ^ ecc_enc(raw[63:32]);
      assign rd_err[p] = ecc_en_q[bank[p]] && ((syn_lo != '0) || (syn_hi != '0));
      // Correction sits in the same cycle as the read, so ECC costs no read latency
      assign view[p]   = ecc_en_q[bank[p]] ? {ecc_fix(raw[63:32], syn_hi), ecc_fix(raw[31:0], syn_lo)} : raw; // R9
      assign busy[p]   = (st[1-p] != ST_IDLE) && (bank[1-p] == bank[p]);
      assign narrow[p] = sel_wr[p] && ecc_en_q[bank[p]] && (partial(ws[p][3:0]) || partial(ws[p][7:4])); // R16
      assign merged    = idle ? byte_merge(wd[p], ws[p], view[p]) : byte_merge(rmw_data_q, rmw_strb_q, view[p]);
      assign wen[p]    = (grant[p] && sel_wr[p] && !narrow[p]) || (st_q == ST_WR); // R17
      assign wword[p]  = (st_q == ST_WR) ? merged_q : merged;
      assign wchk[p]   = {ecc_enc(wword[p][63:32]), ecc_enc(wword[p][31:0])}; // R17

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            st_q       <= ST_IDLE;
            pref_wr_q  <= 1'b0;
            rb_q       <= '0;
            rr_q       <= '0;
            rmw_data_q <= '0;
            rmw_strb_q <= '0;
            merged_q   <= '0;
         end else begin
            unique case (st_q)
               ST_IDLE: begin
                  if (grant[p]) pref_wr_q <= !sel_wr[p]; // R4
                  // Accept cycle is the first read cycle of the sequence
                  if (grant[p] && narrow[p]) begin
                     st_q       <= ST_RD2; // R7 R8
                     rb_q       <= bank[p];
                     rr_q       <= row[p];
                     rmw_data_q <= wd[p];
                     rmw_strb_q <= ws[p];
                  end
               end
               ST_RD2: begin
                  st_q     <= ST_WR; // R7
                  merged_q <= merged;
               end
               ST_WR: st_q <= ST_IDLE; // R7
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Bank conflict arbitration
   logic                 conflict;
   logic                 dma_turn;
   logic [PC_W-1:0]      core_cnt;
   logic [PC_W-1:0]      dma_cnt;
   logic [WAIT_W-1:0]    dma_limit;
   logic [1:0]           err_inc;

   assign conflict  = want[0] && want[1] && (bank[0] == bank[1]);
   assign core_cnt  = sel_wr[0] ? wpc_q[PC_CORE_LSB +: PC_W] : rpc_q[PC_CORE_LSB +: PC_W]; // R12
   assign dma_cnt   = sel_wr[1] ? wpc_q[PC_DMA_LSB +: PC_W] : rpc_q[PC_DMA_LSB +: PC_W]; // R12
   // The core keeps the bank for at least two cycles plus its own count
   assign dma_limit = WAIT_W'(DMA_MIN_WAIT) + WAIT_W'(core_cnt); // R11
   assign dma_turn  = (dma_cnt != '0) && (wait_q >= dma_limit); // R12
   assign grant[0]  = want[0] && !busy[0] && !(conflict && dma_turn);
   assign grant[1]  = want[1] && !busy[1] && !(conflict && !dma_turn); // R11
   assign wait_d    = !(conflict && !dma_turn) ? '0 : (wait_q == '1) ? wait_q : wait_q + 1'b1;

   assign core_wr_ready = grant[0] && sel_wr[0];
   assign core_rd_ready = grant[0] && !sel_wr[0]; // R10
   assign dma_wr_ready  = grant[1] && sel_wr[1];
   assign dma_rd_ready  = grant[1] && !sel_wr[1];

   assign err_inc   = {1'b0, core_rd_ready && rd_err[0]} + {1'b0, dma_rd_ready && rd_err[1]};
   assign err_cnt_d = (err_cnt_q > ERR_W'('1) - ERR_W'(err_inc)) ? '1 : err_cnt_q + ERR_W'(err_inc);

   // Two ports may write in one cycle only to different banks
   always_ff @(posedge clk) begin // R1
      for (int p = 0; p < 2; p++) begin
         if (wen[p]) begin
            mem_q[bank[p]][row[p]] <= wword[p]; // R5 R6
            chk_q[bank[p]][row[p]] <= wchk[p];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q         <= '0;
         err_cnt_q      <= '0;
         core_rd_rvalid <= 1'b0;
         core_rd_rdata  <= '0;
         core_wr_done   <= 1'b0;
         dma_rd_rvalid  <= 1'b0;
         dma_rd_rdata   <= '0;
         dma_wr_done    <= 1'b0;
      end else begin
         wait_q         <= wait_d; // R11
         err_cnt_q      <= err_cnt_d;
         core_rd_rvalid <= core_rd_ready; // R9
         core_wr_done   <= wen[0];
         dma_rd_rvalid  <= dma_rd_ready;
         dma_wr_done    <= wen[1];
         if (core_rd_ready) core_rd_rdata <= view[0]; // R2
         if (dma_rd_ready) dma_rd_rdata <= dma_rd_addr[2] ? view[1][63:32] : view[1][31:0]; // R3
      end
   end

   // AXI4-Lite slave; one outstanding write and one outstanding read
   logic                 aw_take;
   logic                 ar_take;
   logic                 aw_known;
   logic                 ar_known;
   logic                 wr_lane0;
   logic [31:0]          rd_word;

   assign aw_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign ar_take       = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_awready = aw_take;
   assign s_axi_wready  = aw_take;
   assign s_axi_arready = ar_take;
   assign wr_lane0      = aw_take && s_axi_wstrb[0];
   assign aw_known      = (s_axi_awaddr == REG_RPC) || (s_axi_awaddr == REG_WPC) ||
                          (s_axi_awaddr == REG_ECC) || (s_axi_awaddr == REG_STAT);
   assign ar_known      = (s_axi_araddr == REG_RPC) || (s_axi_araddr == REG_WPC) ||
                          (s_axi_araddr == REG_ECC) || (s_axi_araddr == REG_STAT);
   assign rd_word       = (s_axi_araddr == REG_RPC) ? {24'h0, rpc_q} :
                          (s_axi_araddr == REG_WPC) ? {24'h0, wpc_q} :
                          (s_axi_araddr == REG_ECC) ? {24'h0, ecc_en_q} :
                          (s_axi_araddr == REG_STAT) ? {16'h0, err_cnt_q} : 32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rpc_q        <= RPC_RST;
         wpc_q        <= WPC_RST;
         ecc_en_q     <= ECC_EN_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= '0;
      end else begin
         if (wr_lane0 && (s_axi_awaddr == REG_RPC)) rpc_q <= s_axi_wdata[7:0]; // R12
         if (wr_lane0 && (s_axi_awaddr == REG_WPC)) wpc_q <= s_axi_wdata[7:0]; // R12
         if (wr_lane0 && (s_axi_awaddr == REG_ECC)) ecc_en_q <= s_axi_wdata[7:0]; // R16
         if (aw_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ar_known ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= rd_word;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   rmw_seq_a: assert property (@(posedge clk) disable iff (rst) // R7
      grant[0] && narrow[0] |=> st[0] == ST_RD2 ##1 st[0] == ST_WR ##1 st[0] == ST_IDLE)
      else $error("core read-modify-write sequence broken");

   rmw_extra_a: assert property (@(posedge clk) disable iff (rst) // R8
      dma_wr_ready && narrow[1] |=> !dma_wr_done[*2] ##1 (dma_wr_done && st[1] == ST_IDLE))
      else $error("narrow ECC write not finished two cycles late");

   ecc_off_a: assert property (@(posedge clk) disable iff (rst) // R16
      core_wr_ready && !ecc_en_q[bank[0]] |=> st[0] == ST_IDLE && core_wr_done)
      else $error("write to bank without ECC was not direct");

   full_write_a: assert property (@(posedge clk) disable iff (rst) // R17
      core_wr_ready && core_wr_strb == 8'hff |-> wen[0] ##1 (core_wr_done && st[0] == ST_IDLE))
      else $error("full-width write was not written directly");

   read_lat_a: assert property (@(posedge clk) disable iff (rst) // R9
      core_rd_ready || dma_rd_ready |=> core_rd_rvalid || dma_rd_rvalid)
      else $error("read data late");

   dma_half_a: assert property (@(posedge clk) disable iff (rst) // R5
      dma_rd_ready |=> dma_rd_rdata == ($past(dma_rd_addr[2]) ? $past(view[1][63:32]) : $past(view[1][31:0])))
      else $error("DMA read half wrong");

   dma_rate_a: assert property (@(posedge clk) disable iff (rst) // R11
      conflict && grant[1] |=> !(conflict && grant[1]) ##1 !(conflict && grant[1]))
      else $error("DMA won a conflict more than once in three cycles");

   dma_block_a: assert property (@(posedge clk) disable iff (rst) // R12
      conflict && dma_cnt == '0 |-> grant[0] && !grant[1])
      else $error("DMA with zero count won a conflict");

   bank_excl_a: assert property (@(posedge clk) disable iff (rst) // R6
      wen[0] && wen[1] |-> bank[0] != bank[1])
      else $error("both ports wrote one bank");

   any_addr_a: assert property (@(posedge clk) disable iff (rst) // R10
      core_rd_valid && !core_wr_valid && st[0] == ST_IDLE && !busy[0] && !want[1] |-> core_rd_ready)
      else $error("free core read stalled");

   chan_alt_a: assert property (@(posedge clk) disable iff (rst) // R4
      core_rd_ready && core_wr_valid |=> !core_rd_ready)
      else $error("pending write starved by reads");
endmodule : l2sc_ctrl
`default_nettype wire

/* File: l2sc_pkg.sv */
// Shared constants and types for the level-2 SRAM controller
`default_nettype none
package l2sc_pkg;
   localparam int SYS_CLK_MHZ  = 125;
   localparam int CORE_CLK_MHZ = 2 * SYS_CLK_MHZ;
   localparam int ADDR_W       = 18;
   localparam int NUM_BANKS    = 8;
   localparam int BANK_W       = 3;
   localparam int BANK_LSB     = 3;
   localparam int ROW_LSB      = 6;
   localparam int BANK_ROWS    = 4096;
   localparam int CHK_W        = 6;
   localparam int HAM_LEN      = 38;
   localparam int PC_W         = 4;
   localparam int PC_CORE_LSB  = 0;
   localparam int PC_DMA_LSB   = 4;
   localparam int DMA_MIN_WAIT = 2;
   localparam int WAIT_W       = 5;
   localparam int ERR_W        = 16;
   localparam int REG_AW       = 8;
   localparam logic [REG_AW-1:0] REG_RPC  = 8'h00;
   localparam logic [REG_AW-1:0] REG_WPC  = 8'h04;
   localparam logic [REG_AW-1:0] REG_ECC  = 8'h08;
   localparam logic [REG_AW-1:0] REG_STAT = 8'h0c;
   localparam logic [7:0] RPC_RST    = 8'h00;
   localparam logic [7:0] WPC_RST    = 8'h00;
   localparam logic [7:0] ECC_EN_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD2  = 2'b01,
      ST_WR   = 2'b10
   } l2sc_st_type;
endpackage : l2sc_pkg
`default_nettype wire

/* File: l2sc_xbar_model.sv */
// Crossbar-side master model driving the core and DMA memory ports
`timescale 1ns/1ps
`default_nettype none
module l2sc_xbar_model
   import l2sc_pkg::*;
(
   input  wire logic              clk,
   output logic                   core_wr_valid,
   input  wire logic              core_wr_ready,
   output logic [ADDR_W-1:0]      core_wr_addr,
   output logic [63:0]            core_wr_data,
   output logic [7:0]             core_wr_strb,
   input  wire logic              core_wr_done,
   output logic                   core_rd_valid,
   input  wire logic              core_rd_ready,
   output logic [ADDR_W-1:0]      core_rd_addr,
   input  wire logic              core_rd_rvalid,
   input  wire logic [63:0]       core_rd_rdata,
   output logic                   dma_wr_valid,
   input  wire logic              dma_wr_ready,
   output logic [ADDR_W-1:0]      dma_wr_addr,
   output logic [31:0]            dma_wr_data,
   output logic [3:0]             dma_wr_strb,
   input  wire logic              dma_wr_done,
   output logic                   dma_rd_valid,
   input  wire logic              dma_rd_ready,
   output logic [ADDR_W-1:0]      dma_rd_addr,
   input  wire logic              dma_rd_rvalid,
   input  wire logic [31:0]       dma_rd_rdata,
   output var logic               hung
);
   logic              wv [2];
   logic              rv [2];
   logic [ADDR_W-1:0] wa [2];
   logic [ADDR_W-1:0] ra [2];
   logic [63:0]       wd [2];
   logic [7:0]        ws [2];
   logic [1:0]        wr_rdy, wr_dn, rd_rdy, rd_rv;

   assign core_wr_valid = wv[0], core_wr_addr = wa[0], core_wr_data = wd[0], core_wr_strb = ws[0];
   assign dma_wr_valid = wv[1], dma_wr_addr = wa[1], dma_wr_data = wd[1][31:0], dma_wr_strb = ws[1][3:0];
   assign core_rd_valid = rv[0], core_rd_addr = ra[0], dma_rd_valid = rv[1], dma_rd_addr = ra[1];
   assign wr_rdy = {dma_wr_ready, core_wr_ready}, wr_dn = {dma_wr_done, core_wr_done};
   assign rd_rdy = {dma_rd_ready, core_rd_ready}, rd_rv = {dma_rd_rvalid, core_rd_rvalid};

   initial begin
      wv = '{1'b0, 1'b0};
      rv = '{1'b0, 1'b0};
      wa = '{'0, '0};
      ra = '{'0, '0};
      wd = '{'0, '0};
      ws = '{'0, '0};
      hung = 1'b0;
   end

   // Single write; lat counts edges from acceptance to the done pulse
   task automatic wr(input bit p, input logic [ADDR_W-1:0] a, input logic [63:0] d, input logic [7:0] s,
                     output int lat);
      int i;
      @(posedge clk);
      wv[p] <= 1'b1;
      wa[p] <= a;
      wd[p] <= d;
      ws[p] <= s;
      for (i = 0; i < 64 && !wr_rdy[p]; i++) @(posedge clk);
      wv[p] <= 1'b0;
      // Released lines show garbage, never the stale value
      wa[p] <= ~a;
      wd[p] <= ~d;
      ws[p] <= ~s;
      for (lat = 1; lat < 64; lat++) begin
         @(posedge clk);
         if (wr_dn[p]) break;
      end
      if (i == 64 || lat == 64) hung <= 1'b1;
   endtask : wr

   // Valid held across n accesses, addresses visited out of order in multiples of step
   task automatic rd(input bit p, input logic [ADDR_W-1:0] a, input int n, input int step, output int cyc,
                     output logic ok, output logic [63:0] q);
      int k;
      k = 0;
      cyc = 0;
      @(posedge clk);
      rv[p] <= 1'b1;
      ra[p] <= a;
      while (k < n && cyc < 200) begin
         @(posedge clk);
         cyc++;
         if (rd_rdy[p]) begin
            k++;
            ra[p] <= a + ADDR_W'(step * ((k * 5) % 16));
         end
      end
      rv[p] <= 1'b0;
      @(posedge clk);
      ok = rd_rv[p];
      q = p ? {32'h0, dma_rd_rdata} : core_rd_rdata;
      if (cyc == 200) hung <= 1'b1;
   endtask : rd
endmodule : l2sc_xbar_model
`default_nettype wire
